// ==== common/dce_pkg.sv ====
package dce_pkg;
   // ---------------------------------------------------------------
   // command codes
   // ---------------------------------------------------------------
   localparam logic [7:0] CMD_NOP = 8'h00;
   localparam logic [7:0] CMD_GO = 8'h08;
   localparam logic [7:0] CMD_WR_MEM = 8'h10;
   localparam logic [7:0] CMD_FILL_MEM = 8'h12;
   localparam logic [7:0] CMD_RD_MEM = 8'h30;
   localparam logic [7:0] CMD_MEM_MASK = 8'hf2;
   localparam logic [7:0] CMD_GP_RD = 8'h60;
   localparam logic [7:0] CMD_GP_MASK = 8'hf0;
   localparam logic [7:0] CMD_DREG_RD = 8'ha0;
   localparam logic [7:0] CMD_TRACE_RD = 8'hc0;
   localparam logic [7:0] CMD_CREG_RD = 8'he0;
   localparam logic [7:0] CMD_REG5_MASK = 8'he0;
   localparam logic [7:0] CMD_TRACE_MASK = 8'hf0;
   localparam logic [7:0] ILLEGAL_RESP = 8'hee;
   localparam int WS_BIT = 0;
   localparam int SZ_LSB = 2;
   // ---------------------------------------------------------------
   // sizes and timing
   // ---------------------------------------------------------------
   localparam logic [1:0] SZ_BYTE = 2'h0;
   localparam logic [1:0] SZ_WORD = 2'h1;
   localparam logic [1:0] SZ_LONG = 2'h2;
   localparam logic [2:0] ADDR_LAST = 3'h2;
   localparam logic [2:0] REG_BYTES = 3'h4;
   localparam logic [4:0] DLY_CYCLES = 5'h10;
   localparam int TRACE_ENTRIES = 64;
   localparam int TRACE_WORDS = 12;
   localparam int TRACE_BITS = 384;
   // ---------------------------------------------------------------
   // register map, byte addresses and fields
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_CFG_STATUS = 8'h00;
   localparam logic [7:0] OFS_EXT_STATUS = 8'h04;
   localparam logic [7:0] OFS_CFG_SECOND = 8'h08;
   localparam logic [7:0] OFS_CFG_THIRD = 8'h0c;
   localparam logic [7:0] OFS_ACCESS_ATTR = 8'h10;
   localparam logic [4:0] CRN_CFG_STATUS = 5'h00;
   localparam logic [4:0] CRN_EXT_STATUS = 5'h01;
   localparam logic [4:0] CRN_CFG_SECOND = 5'h02;
   localparam logic [4:0] CRN_CFG_THIRD = 5'h03;
   localparam logic [4:0] CRN_ACCESS_ATTR = 5'h04;
   localparam int XS_HALT_BIT = 31;
   localparam int XS_ILL_BIT = 30;
   localparam int TM_LSB = 0;
   localparam int TT_LSB = 4;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [31:0] REG_RESET = 32'h0000_0000;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_ADDR  = 3'b001,
      ST_WDATA = 3'b011,
      ST_BUSY  = 3'b010,
      ST_DELAY = 3'b110,
      ST_SEND  = 3'b111
   } dce_state_t;
endpackage : dce_pkg

// ==== core/dce_executor.sv ====
// Summary of operation
// RQ1 - fill command without a prior addressed write answers illegal
// RQ2 - after each write the pointer advances by 1, 2 or 4 bytes
// RQ3 - fill with status sends status byte after the write data
// RQ4 - that status byte shows core state after the write finished
// RQ5 - fill only legal after nop, addressed write or fill; else illegal
// RQ6 - nop leaves the block pointer untouched
// RQ7 - operand size decoded afresh on every fill command
// RQ8 - resume while halted pulses the restart of execution
// RQ9 - resume uses registers as changed during halt
// RQ10 - resume while running is ignored
// RQ11 - nop does nothing and is always accepted
// RQ12 - cpu control register read returns 32 bits while halted
// RQ13 - cpu control register read while running answers illegal
// RQ14 - debug register read at 0xa0 plus number, 32 bits, never halts
// RQ15 - read with status: code, three address bytes, status then data msb first
// RQ16 - memory reads take type and modifier from access attributes
// RQ17 - word and longword addresses forced to size alignment
// RQ18 - read status byte sent first, sampled after the read finished
// RQ19 - trace read returns one of 12 packed longwords of 64 entries
// RQ20 - trace write pointer readable in second config register
// RQ21 - gp register read at 0x60 plus number, illegal unless halted
// RQ22 - host waits out the delay slot before clocking answers
//
// Local design decisions: the AXI4-Lite interface to the registers and the register addresses.
module dce_executor (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   output logic rx_ready,
   output logic tx_valid,
   output logic [7:0] tx_data,
   input wire logic tx_ready,
   output logic mem_req,
   output logic mem_we,
   output logic [23:0] mem_addr,
   output logic [1:0] mem_size,
   output logic [31:0] mem_wdata,
   output logic [1:0] mem_tt,
   output logic [2:0] mem_tm,
   input wire logic mem_ack,
   input wire logic [31:0] mem_rdata,
   input wire logic cpu_halted,
   output logic cpu_go,
   output logic cpu_rd_req,
   output logic cpu_rd_ctrl,
   output logic [4:0] cpu_rd_sel,
   input wire logic cpu_rd_ack,
   input wire logic [31:0] cpu_rd_data,
   input wire logic trace_valid,
   input wire logic [5:0] trace_entry,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [7:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp
);
   import dce_pkg::*;

   typedef struct packed {
      dce_state_t st;
      logic [2:0] cnt;
      logic op_rd;
      logic ws;
      logic [1:0] sz;
      logic [23:0] addr;
      logic [31:0] wdata;
      logic [23:0] ptr;
      logic fill_ok;
      logic illegal;
      logic [39:0] txbuf;
      logic [2:0] txn;
      logic [4:0] dly;
      logic rx_ready;
      logic tx_valid;
      logic mem_req;
      logic mem_we;
      logic [23:0] mem_addr;
      logic [1:0] mem_size;
      logic [31:0] mem_wdata;
      logic [1:0] mem_tt;
      logic [2:0] mem_tm;
      logic go;
      logic cpu_req;
      logic cpu_ctrl;
      logic [4:0] cpu_sel;
      logic [31:0] cfg_status;
      logic [29:0] ext_low;
      logic [31:0] cfg_second;
      logic [31:0] cfg_third;
      logic [31:0] attr;
      logic [TRACE_BITS-1:0] trace;
      logic [5:0] tptr;
      logic aw_have;
      logic [7:0] aw_addr;
      logic w_have;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } dce_regs_t;

   dce_regs_t s_r;
   dce_regs_t s_nxt;

   function automatic logic [2:0] sz_bytes(input logic [1:0] sz);
      if (sz == SZ_BYTE) begin
         return 3'h1;
      end else if (sz == SZ_WORD) begin
         return 3'h2;
      end
      return REG_BYTES;
   endfunction : sz_bytes

   function automatic logic [23:0] align(input logic [23:0] a, input logic [1:0] sz);
      if (sz == SZ_LONG) begin
         return {a[23:2], 2'b00};
      end else if (sz == SZ_WORD) begin
         return {a[23:1], 1'b0};
      end
      return a;
   endfunction : align

   // ---------------------------------------------------------------
   // debug register view
   // ---------------------------------------------------------------
   logic [31:0] ext_status;
   logic [7:0] core_status;
   logic [31:0] second_view;
   assign ext_status = {cpu_halted, s_r.illegal, s_r.ext_low};
   assign core_status = ext_status[31:24];
   assign second_view = {s_r.cfg_second[31:6], s_r.tptr}; // RQ20

   function automatic logic [31:0] dreg(input logic [4:0] register_select_number, input logic [31:0] xs,
                                        input logic [31:0] c2, input dce_regs_t r);
      if (register_select_number == CRN_CFG_STATUS) begin
         return r.cfg_status;
      end else if (register_select_number == CRN_EXT_STATUS) begin
         return xs;
      end else if (register_select_number == CRN_CFG_SECOND) begin
         return c2;
      end else if (register_select_number == CRN_CFG_THIRD) begin
         return r.cfg_third;
      end else if (register_select_number == CRN_ACCESS_ATTR) begin
         return r.attr;
      end
      return REG_RESET;
   endfunction : dreg

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      logic rx_take;
      logic respond;
      logic [31:0] al;
      logic [2:0] nb;
      logic [8:0] tw;
      logic [31:0] wv;
      logic [7:0] ofs;
      logic set_ill;
      rx_take = rx_valid & s_r.rx_ready;
      respond = 1'b0;
      al = 32'h0;
      nb = sz_bytes(s_r.sz);
      tw = 9'(s_r.tptr) * 9'd6;
      wv = 32'h0;
      ofs = 8'h0;
      set_ill = 1'b0;
      s_nxt = s_r;
      s_nxt.go = 1'b0;

      case (s_r.st)
         ST_IDLE: begin
            if (rx_take) begin
               s_nxt.cnt = 3'h0;
               s_nxt.ws = rx_data[WS_BIT];
               s_nxt.sz = rx_data[SZ_LSB +: 2];
               if (rx_data == CMD_NOP) begin
                  s_nxt.st = ST_IDLE; // RQ6 RQ11
               end else if ((rx_data & CMD_MEM_MASK) == CMD_WR_MEM) begin
                  s_nxt.op_rd = 1'b0;
                  s_nxt.st = ST_ADDR;
               end else if ((rx_data & CMD_MEM_MASK) == CMD_FILL_MEM) begin
                  if (s_r.fill_ok) begin // RQ1 RQ5
                     s_nxt.op_rd = 1'b0;
                     s_nxt.addr = s_r.ptr; // RQ7
                     s_nxt.st = ST_WDATA;
                  end else begin
                     set_ill = 1'b1;
                  end
               end else if ((rx_data & CMD_MEM_MASK) == CMD_RD_MEM) begin
                  s_nxt.op_rd = 1'b1; // RQ15
                  s_nxt.fill_ok = 1'b0;
                  s_nxt.st = ST_ADDR;
               end else begin
                  s_nxt.fill_ok = 1'b0;
                  if (rx_data == CMD_GO) begin
                     s_nxt.go = cpu_halted; // RQ8 RQ9 RQ10
                  end else if ((rx_data & CMD_REG5_MASK) == CMD_DREG_RD) begin
                     s_nxt.txbuf = {dreg(rx_data[4:0], ext_status, second_view, s_r), 8'h00};
                     s_nxt.txn = REG_BYTES; // RQ14
                     respond = 1'b1;
                  end else if ((rx_data & CMD_TRACE_MASK) == CMD_TRACE_RD) begin
                     if (int'(rx_data[3:0]) < TRACE_WORDS) begin
                        al = s_r.trace[{rx_data[3:0], 5'h0} +: 32]; // RQ19
                     end
                     s_nxt.txbuf = {al, 8'h00};
                     s_nxt.txn = REG_BYTES;
                     respond = 1'b1;
                  end else if ((rx_data & CMD_GP_MASK) == CMD_GP_RD ||
                               (rx_data & CMD_REG5_MASK) == CMD_CREG_RD) begin
                     if (cpu_halted) begin // RQ12 RQ13 RQ21
                        s_nxt.cpu_req = 1'b1;
                        s_nxt.cpu_ctrl = rx_data[7];
                        s_nxt.cpu_sel = rx_data[4:0];
                        s_nxt.st = ST_BUSY;
                     end else begin
                        set_ill = 1'b1;
                     end
                  end
               end
            end
         end
         ST_ADDR: begin
            if (rx_take) begin
               s_nxt.addr = {s_r.addr[15:0], rx_data}; // RQ15
               s_nxt.cnt = s_r.cnt + 3'h1;
               if (s_r.cnt == ADDR_LAST) begin
                  s_nxt.cnt = 3'h0;
                  if (s_r.op_rd) begin
                     s_nxt.mem_req = 1'b1;
                     s_nxt.mem_we = 1'b0;
                     s_nxt.mem_addr = align({s_r.addr[15:0], rx_data}, s_r.sz); // RQ17
                     s_nxt.mem_size = s_r.sz;
                     s_nxt.mem_tt = s_r.attr[TT_LSB +: 2]; // RQ16
                     s_nxt.mem_tm = s_r.attr[TM_LSB +: 3];
                     s_nxt.st = ST_BUSY;
                  end else begin
                     s_nxt.st = ST_WDATA;
                  end
               end
            end
         end
         ST_WDATA: begin
            if (rx_take) begin
               s_nxt.wdata = {s_r.wdata[23:0], rx_data};
               s_nxt.cnt = s_r.cnt + 3'h1;
               if (s_r.cnt + 3'h1 == nb) begin
                  s_nxt.mem_req = 1'b1;
                  s_nxt.mem_we = 1'b1;
                  s_nxt.mem_addr = align(s_r.addr, s_r.sz); // RQ17
                  s_nxt.mem_size = s_r.sz;
                  s_nxt.mem_wdata = {s_r.wdata[23:0], rx_data};
                  s_nxt.mem_tt = s_r.attr[TT_LSB +: 2];
                  s_nxt.mem_tm = s_r.attr[TM_LSB +: 3];
                  s_nxt.st = ST_BUSY;
               end
            end
         end
         ST_BUSY: begin
            if (s_r.mem_req && mem_ack) begin
               s_nxt.mem_req = 1'b0;
               if (s_r.mem_we) begin
                  s_nxt.ptr = s_r.mem_addr + 24'(nb); // RQ2
                  s_nxt.fill_ok = 1'b1;
                  s_nxt.st = ST_IDLE;
                  if (s_r.ws) begin
                     s_nxt.txbuf = {core_status, 32'h0}; // RQ3 RQ4
                     s_nxt.txn = 3'h1;
                     respond = 1'b1;
                  end
               end else begin
                  al = mem_rdata << (6'd32 - {nb, 3'h0});
                  s_nxt.txbuf = s_r.ws ? {core_status, al} : {al, 8'h00}; // RQ18
                  s_nxt.txn = nb + {2'h0, s_r.ws};
                  respond = 1'b1;
               end
            end else if (s_r.cpu_req && cpu_rd_ack) begin
               s_nxt.cpu_req = 1'b0;
               s_nxt.txbuf = {cpu_rd_data, 8'h00}; // RQ12
               s_nxt.txn = REG_BYTES;
               respond = 1'b1;
            end
         end
         ST_DELAY: begin
            s_nxt.dly = s_r.dly - 5'h1;
            if (s_r.dly == 5'h1) begin
               s_nxt.st = ST_SEND; // RQ22
            end
         end
         ST_SEND: begin
            if (tx_ready) begin
               s_nxt.txbuf = {s_r.txbuf[31:0], 8'h00};
               s_nxt.txn = s_r.txn - 3'h1;
               if (s_r.txn == 3'h1) begin
                  s_nxt.st = ST_IDLE;
               end
            end
         end
         default: begin
            s_nxt.st = ST_IDLE;
         end
      endcase

      if (set_ill) begin
         s_nxt.txbuf = {ILLEGAL_RESP, 32'h0};
         s_nxt.txn = 3'h1;
         s_nxt.fill_ok = 1'b0;
         respond = 1'b1;
      end
      if (respond) begin
         s_nxt.st = ST_DELAY;
         s_nxt.dly = DLY_CYCLES;
      end

      // trace capture, packed six bits per entry
      if (trace_valid) begin
         s_nxt.trace[tw +: 6] = trace_entry;
         s_nxt.tptr = s_r.tptr + 6'h1;
      end

      // register bus write side
      if (s_axi_awvalid && s_r.awready) begin
         s_nxt.aw_have = 1'b1;
         s_nxt.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_r.wready) begin
         s_nxt.w_have = 1'b1;
         s_nxt.w_data = s_axi_wdata;
         s_nxt.w_strb = s_axi_wstrb;
      end
      if (s_r.bvalid && s_axi_bready) begin
         s_nxt.bvalid = 1'b0;
      end
      if (s_r.aw_have && s_r.w_have && !s_r.bvalid) begin
         for (int i = 0; i < 4; i++) begin
            wv[i*8 +: 8] = s_r.w_strb[i] ? s_r.w_data[i*8 +: 8] : 8'h00;
         end
         s_nxt.aw_have = 1'b0;
         s_nxt.w_have = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = RESP_OKAY;
         ofs = s_r.aw_addr;
         for (int i = 0; i < 4; i++) begin
            if (s_r.w_strb[i]) begin
               if (ofs == OFS_CFG_STATUS) begin
                  s_nxt.cfg_status[i*8 +: 8] = wv[i*8 +: 8];
               end else if (ofs == OFS_CFG_SECOND) begin
                  s_nxt.cfg_second[i*8 +: 8] = wv[i*8 +: 8];
               end else if (ofs == OFS_CFG_THIRD) begin
                  s_nxt.cfg_third[i*8 +: 8] = wv[i*8 +: 8];
               end else if (ofs == OFS_ACCESS_ATTR) begin
                  s_nxt.attr[i*8 +: 8] = wv[i*8 +: 8];
               end else if (ofs == OFS_EXT_STATUS && i < 3) begin
                  s_nxt.ext_low[i*8 +: 8] = wv[i*8 +: 8];
               end
            end
         end
         if (ofs == OFS_EXT_STATUS) begin
            s_nxt.ext_low[29:24] = s_r.w_strb[3] ? wv[29:24] : s_r.ext_low[29:24];
            if (wv[XS_ILL_BIT]) begin
               s_nxt.illegal = 1'b0;
            end
         end else if (ofs != OFS_CFG_STATUS && ofs != OFS_CFG_SECOND &&
                      ofs != OFS_CFG_THIRD && ofs != OFS_ACCESS_ATTR) begin
            s_nxt.bresp = RESP_SLVERR;
         end
      end
      // a new illegal event beats a clear in the same cycle
      if (set_ill) begin
         s_nxt.illegal = 1'b1;
      end
      s_nxt.awready = !s_nxt.aw_have && !s_nxt.bvalid;
      s_nxt.wready = !s_nxt.w_have && !s_nxt.bvalid;

      // register bus read side
      if (s_r.rvalid && s_axi_rready) begin
         s_nxt.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_r.arready) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp = RESP_OKAY;
         if (s_axi_araddr == OFS_CFG_STATUS) begin
            s_nxt.rdata = s_r.cfg_status;
         end else if (s_axi_araddr == OFS_EXT_STATUS) begin
            s_nxt.rdata = ext_status;
         end else if (s_axi_araddr == OFS_CFG_SECOND) begin
            s_nxt.rdata = second_view; // RQ20
         end else if (s_axi_araddr == OFS_CFG_THIRD) begin
            s_nxt.rdata = s_r.cfg_third;
         end else if (s_axi_araddr == OFS_ACCESS_ATTR) begin
            s_nxt.rdata = s_r.attr;
         end else begin
            s_nxt.rdata = REG_RESET;
            s_nxt.rresp = RESP_SLVERR;
         end
      end
      s_nxt.arready = !s_nxt.rvalid;

      s_nxt.rx_ready = (s_nxt.st == ST_IDLE) || (s_nxt.st == ST_ADDR) ||
                       (s_nxt.st == ST_WDATA);
      s_nxt.tx_valid = (s_nxt.st == ST_SEND);
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         s_r <= '0;
         s_r.st <= ST_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign rx_ready = s_r.rx_ready;
   assign tx_valid = s_r.tx_valid;
   assign tx_data = s_r.txbuf[39:32];
   assign mem_req = s_r.mem_req;
   assign mem_we = s_r.mem_we;
   assign mem_addr = s_r.mem_addr;
   assign mem_size = s_r.mem_size;
   assign mem_wdata = s_r.mem_wdata;
   assign mem_tt = s_r.mem_tt;
   assign mem_tm = s_r.mem_tm;
   assign cpu_go = s_r.go;
   assign cpu_rd_req = s_r.cpu_req;
   assign cpu_rd_ctrl = s_r.cpu_ctrl;
   assign cpu_rd_sel = s_r.cpu_sel;
   assign s_axi_awready = s_r.awready;
   assign s_axi_wready = s_r.wready;
   assign s_axi_bvalid = s_r.bvalid;
   assign s_axi_bresp = s_r.bresp;
   assign s_axi_arready = s_r.arready;
   assign s_axi_rvalid = s_r.rvalid;
   assign s_axi_rdata = s_r.rdata;
   assign s_axi_rresp = s_r.rresp;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   a_go_when_halted: assert property (s_r.go |-> $past(cpu_halted) ##1 !s_r.go) // RQ10
      else $error("resume pulse without halt");
   a_fill_illegal: assert property (s_r.st == ST_IDLE && rx_valid && s_r.rx_ready && // RQ1
      (rx_data & CMD_MEM_MASK) == CMD_FILL_MEM && !s_r.fill_ok
      |=> s_r.st == ST_DELAY && s_r.txbuf[39:32] == ILLEGAL_RESP)
      else $error("fill without setup not refused");
   a_nop_keeps_ptr: assert property (s_r.st == ST_IDLE && rx_valid && s_r.rx_ready && // RQ6
      rx_data == CMD_NOP |=> $stable(s_r.ptr) && $stable(s_r.fill_ok) && s_r.st == ST_IDLE)
      else $error("nop disturbed pointer");
   a_ptr_advance: assert property (s_r.mem_req && s_r.mem_we && mem_ack // RQ2
      |=> s_r.ptr == $past(s_r.mem_addr) + 24'(sz_bytes($past(s_r.mem_size))))
      else $error("pointer not advanced by size");
   a_long_align: assert property (s_r.mem_req && s_r.mem_size == SZ_LONG // RQ17
      |-> s_r.mem_addr[1:0] == 2'b00)
      else $error("long access misaligned");
   a_attr_used: assert property ($rose(s_r.mem_req) // RQ16
      |-> s_r.mem_tt == $past(s_r.attr[TT_LSB +: 2]) && s_r.mem_tm == $past(s_r.attr[TM_LSB +: 3]))
      else $error("attributes not applied");
   a_reg_rd_halted: assert property ($rose(s_r.cpu_req) |-> $past(cpu_halted)) // RQ13
      else $error("cpu register read while running");
   a_status_first: assert property (s_r.mem_req && !s_r.mem_we && mem_ack && s_r.ws // RQ18
      |=> s_r.txbuf[39] == $past(cpu_halted) && s_r.txn == sz_bytes($past(s_r.mem_size)) + 3'h1)
      else $error("read status byte wrong");
   a_delay_slot: assert property ($rose(s_r.st == ST_DELAY) // RQ22
      |-> (s_r.st == ST_DELAY && !s_r.tx_valid) [*8])
      else $error("answer before delay slot");
   a_dreg_width: assert property (s_r.st == ST_IDLE && rx_valid && s_r.rx_ready && // RQ14
      (rx_data & CMD_REG5_MASK) == CMD_DREG_RD |=> s_r.txn == REG_BYTES)
      else $error("debug register read not 32 bits");
endmodule : dce_executor

// ==== testbench/dce_host_model.sv ====
module dce_host_model (
   input wire logic sys_clk,
   output logic rx_valid,
   output logic [7:0] rx_data,
   input wire logic rx_ready,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   output logic tx_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      rx_valid = 1'b0;
      rx_data = 8'h00;
      tx_ready = 1'b0;
   end
   task put(input logic [7:0] b);
      rx_valid <= 1'b1;
      rx_data <= b;
      do @(posedge sys_clk); while (rx_ready !== 1'b1);
      rx_valid <= 1'b0;
      rx_data <= ~b;
      @(posedge sys_clk);
   endtask : put
   task get(output logic [7:0] b);
      tx_ready <= 1'b1;
      do @(posedge sys_clk); while (tx_valid !== 1'b1);
      b = tx_data;
      tx_ready <= 1'b0;
      @(posedge sys_clk);
   endtask : get
endmodule : dce_host_model

// ==== testbench/tb_top.sv ====
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk, srst, rx_valid, rx_ready, tx_valid, tx_ready, mem_req, mem_we, mem_ack;
   logic cpu_halted, cpu_go, cpu_rd_req, cpu_rd_ctrl, cpu_rd_ack, trace_valid;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0] rx_data, tx_data, s_axi_awaddr, s_axi_araddr;
   logic [23:0] mem_addr, la;
   logic [1:0] mem_size, mem_tt, s_axi_bresp, s_axi_rresp, lt;
   logic [2:0] mem_tm, lm;
   logic [31:0] mem_wdata, mem_rdata, cpu_rd_data, s_axi_wdata, s_axi_rdata, lw, v, a, d, seed;
   logic [4:0] cpu_rd_sel;
   logic [5:0] trace_entry;
   logic [3:0] s_axi_wstrb;
   int mismatches, n_checks, cyc, gos;
   dce_executor dut (.*);
   dce_host_model host (.*);
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      mem_ack <= mem_req && !mem_ack;
      mem_rdata <= md(mem_addr);
      cpu_rd_ack <= cpu_rd_req && !cpu_rd_ack;
      cpu_rd_data <= {cpu_rd_ctrl, 26'h0, cpu_rd_sel};
      if (mem_req) {la, lw, lt, lm} <= {mem_addr, mem_wdata, mem_tt, mem_tm};
      if (cpu_go) gos <= gos + 1;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         mismatches++;
         wrap_up();
      end
   end
   function logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   function logic [31:0] md(input logic [23:0] x);
      return {x[7:0] ^ 8'h5a, x};
   endfunction : md
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task snd(input logic [31:0] x, input int n);
      for (int i = n - 1; i >= 0; i--) host.put(x[8*i+:8]);
   endtask : snd
   task rx(input int n);
      logic [7:0] b;
      v = 32'h0;
      repeat (n) begin
         host.get(b);
         v = {v[23:0], b};
      end
   endtask : rx
   task xc(input logic [7:0] c, input int n, input logic [31:0] e, input string nm);
      host.put(c);
      rx(n);
      chk(nm, v, e);
   endtask : xc
   task axw(input logic [7:0] ad, input logic [31:0] dt);
      s_axi_awaddr <= ad;
      s_axi_wdata <= dt;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do begin
         @(posedge sys_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
      do @(posedge sys_clk); while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      @(posedge sys_clk);
   endtask : axw
   task axr(input logic [7:0] ad);
      s_axi_araddr <= ad;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do @(posedge sys_clk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge sys_clk); while (!s_axi_rvalid);
      v = s_axi_rdata;
      a = {30'h0, s_axi_rresp};
      s_axi_rready <= 1'b0;
      @(posedge sys_clk);
   endtask : axr
   task wrap_up();
      if (mismatches == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : wrap_up
   initial begin
      {srst, mem_ack, cpu_rd_ack, cpu_halted, trace_valid, trace_entry} = 11'h400;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, mem_rdata, cpu_rd_data} = 112'h0;
      s_axi_wstrb = 4'hf;
      {mismatches, n_checks, cyc, gos} = 128'h0;
      seed = 32'h0000e01e;
      repeat (16) @(posedge sys_clk);
      srst <= 1'b0;
      @(posedge sys_clk);
      xc(8'h12, 1, 32'hee, "fill_first");
      for (int k = 0; k < 3; k++) begin
         trace_valid <= 1'b1;
         trace_entry <= 6'h2a + 6'(k);
         @(posedge sys_clk);
      end
      trace_valid <= 1'b0;
      axw(8'h10, 32'h21);
      a = xs();
      d = xs();
      host.put(8'h18);
      snd(a, 3);
      snd(d, 4);
      host.put(8'h00);
      chk("wr_addr", {8'h0, la}, {8'h0, a[23:2], 2'h0});
      chk("wr_data", lw, d);
      host.put(8'h17);
      snd(d, 2);
      rx(1);
      chk("fill_status", v, 32'h40);
      chk("fill_word", {8'h0, la}, {8'h0, a[23:2], 2'h0} + 32'h4);
      host.put(8'h12);
      snd(d, 1);
      host.put(8'h00);
      chk("fill_byte", {8'h0, la}, {8'h0, a[23:2], 2'h0} + 32'h6);
      for (int s = 0; s < 3; s++) begin
         a = xs();
         host.put(8'h31 + 8'(4 * s));
         chk("rd_cmd", {31'h0, rx_ready}, 32'h1);
         snd(a, 3);
         rx(1);
         chk("rd_status", v, 32'h40);
         rx(1 << s);
         a[23:0] = a[23:0] & ~24'((1 << s) - 1);
         chk("rd_data", v, 32'(md(a[23:0]) & ((64'h1 << (8 << s)) - 1)));
         chk("rd_addr", {8'h0, la}, {8'h0, a[23:0]});
         chk("rd_attr", {27'h0, lt, lm}, 32'h11);
      end
      xc(8'h12, 1, 32'hee, "fill_after_read");
      xc(8'ha4, 4, 32'h21, "dreg");
      xc(8'hc0, 4, {14'h0, 6'h2c, 6'h2b, 6'h2a}, "trace");
      axr(8'h08);
      chk("trace_ptr", {26'h0, v[5:0]}, 32'h3);
      axr(8'h40);
      chk("unmapped", a, 32'h2);
      host.put(8'h08);
      cpu_halted <= 1'b1;
      host.put(8'h08);
      xc(8'he3, 4, 32'h80000003, "creg");
      chk("go_count", gos, 32'h1);
      xc(8'h65, 4, 32'h5, "gp");
      cpu_halted <= 1'b0;
      xc(8'he3, 1, 32'hee, "creg_run");
      xc(8'h65, 1, 32'hee, "gp_run");
      axw(8'h04, 32'h4000_0000);
      axr(8'h04);
      chk("ill_clear", v, 32'h0);
      s_axi_wstrb <= 4'h5;
      axw(8'h0c, d);
      axr(8'h0c);
      chk("strobe", v, d & 32'h00ff00ff);
      xc(8'ha3, 4, d & 32'h00ff00ff, "third");
      wrap_up();
   end
endmodule : tb_top
